// ==== usi_dev.sv ====
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Functional notes
// - master clocks, slave stretches, both shift
// - master confirms SCL high after release
// - start: SDA low while SCL high
// - start condition sets start flag
// - hold SCL low after start until cleared
// - slave samples SDA on SCL rise
// - address byte overflow forces SCL low in hold mode only
// - slave acks, presets counter to 14
// - read bit one: slave drives data
// - start detector only in two-wire mode
// - start detection wakes sleeping processor
// - external clock counts both edges
// - preset max: next edge overflows
// - cpu write beats simultaneous shift
// - left shift from selected clock source
// - bit 7 out through transparent latch
// - copy shift register to buffer on completion
// - other modes, external clock select: clock edges set start flag
// - start flag write-one clears, releases hold
// - wrap flag at 15 to 0, releases
// - stop flag set, write-one clears
// - collision when bit 7 differs from SDA
// - hold mode also stretches after overflow
module usi_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tim_match,
  output logic             event_req,
  output logic             dout,
  usi_if.dev               bus
);
  import usi_pkg::*;

  logic [1:0] s1_r, s2_r, s3_r, filt_r;
  logic [1:0] edge_r, edge_f;
  logic [7:0] data_r, buf_r, data_nxt;
  logic [3:0] cnt_r;
  logic       start_f_r, wrap_f_r, stop_f_r;
  logic       sie_r, oie_r, clk_strobe_r;
  logic [1:0] wm_r, cs_r;
  logic [3:0] port_r;
  logic       latch_r, start_hold_r;
  logic       scl_oe_n_r, sda_oe_n_r;
  logic       wr, dr_wr, st_wr, ct_wr, pt_wr;
  logic       sw_clk, tog_clk, shift_clk, cnt_clk, wrap;
  logic       start_det, stop_det, ext_start;
  logic       scl_stable_hi;

  // pins: three stages, a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
      filt_r <= 2'h3;
    end else begin
      s1_r <= {bus.sda, bus.scl};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= {(s2_r[1] == s3_r[1]) ? s3_r[1] : filt_r[1],
                 (s2_r[0] == s3_r[0]) ? s3_r[0] : filt_r[0]};
    end
  end

  // edge pulses per line
  for (genvar i = 0; i < 2; i++) begin : g_edge
    assign edge_r[i] = (s2_r[i] == s3_r[i]) & s3_r[i] & ~filt_r[i];
    assign edge_f[i] = (s2_r[i] == s3_r[i]) & ~s3_r[i] & filt_r[i];
  end

  // register writes land at the access edge only
  assign wr    = psel & penable & pready & pwrite;
  assign dr_wr = wr & (paddr == OFS_DATA);
  assign st_wr = wr & (paddr == OFS_STAT);
  assign ct_wr = wr & (paddr == OFS_CTRL);
  assign pt_wr = wr & (paddr == OFS_PORT);
  assign sw_clk  = ct_wr & pwdata[CT_CLK];
  assign tog_clk = ct_wr & pwdata[CT_TC];

  // sda is judged against an scl that has already settled
  assign scl_stable_hi = filt_r[0] & s2_r[0] & s3_r[0];
  assign start_det = wm_r[1] & scl_stable_hi & edge_f[1];
  assign stop_det  = wm_r[1] & scl_stable_hi & edge_r[1];
  assign ext_start = ~wm_r[1] & cs_r[1] & ~clk_strobe_r & (edge_r[0] | edge_f[0]);

  // clock source for shift and counter
  always_comb begin
    case (cs_r)
      CS_SOFT:    shift_clk = sw_clk;
      CS_TIMER:   shift_clk = tim_match;
      CS_EXT_POS: shift_clk = edge_r[0];
      CS_EXT_NEG: shift_clk = edge_f[0];
      default:    shift_clk = 1'b0;
    endcase
  end
  // external clock counts both edges, or the toggle strobe
  assign cnt_clk = ~cs_r[1] ? shift_clk : (clk_strobe_r ? tog_clk : (edge_r[0] | edge_f[0]));
  assign wrap    = cnt_clk & (cnt_r == CNT_MAX) & ~st_wr;
  assign data_nxt = dr_wr ? pwdata[7:0] : (shift_clk ? {data_r[6:0], filt_r[1]} : data_r);

  // shift register and receive buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= RST_BYTE;
      buf_r <= RST_BYTE;
    end else begin
      data_r <= data_nxt;
      if (wrap) buf_r <= data_nxt;
    end
  end

  // edge counter; software preset wins over a count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 4'h0;
    else if (st_wr) cnt_r <= pwdata[3:0];
    else if (cnt_clk) cnt_r <= cnt_r + 4'h1;
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_f_r <= 1'b0;
      wrap_f_r <= 1'b0;
      stop_f_r <= 1'b0;
    end else begin
      if (start_det | ext_start) start_f_r <= 1'b1;
      else if (st_wr & pwdata[ST_START]) start_f_r <= 1'b0;
      if (wrap) wrap_f_r <= 1'b1;
      else if (st_wr & pwdata[ST_WRAP]) wrap_f_r <= 1'b0;
      if (stop_det) stop_f_r <= 1'b1;
      else if (st_wr & pwdata[ST_STOP]) stop_f_r <= 1'b0;
    end
  end

  // control and port registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sie_r <= 1'b0;
      oie_r <= 1'b0;
      wm_r <= 2'h0;
      cs_r <= 2'h0;
      clk_strobe_r <= 1'b0;
      port_r <= RST_PORT;
    end else begin
      if (ct_wr) begin
        sie_r <= pwdata[CT_SIE];
        oie_r <= pwdata[CT_OIE];
        wm_r <= pwdata[CT_WM +: 2];
        cs_r <= pwdata[CT_CS +: 2];
        clk_strobe_r <= pwdata[CT_CLK];
      end
      if (pt_wr) port_r <= pwdata[3:0];
      else if (tog_clk) port_r[PT_SCL] <= ~port_r[PT_SCL];
    end
  end

  // output latch keeps data stable across the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) latch_r <= 1'b0;
    else if (~cs_r[1] | (filt_r[0] == cs_r[0])) latch_r <= data_r[7];
  end

  // start stretch begins at the master's scl fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) start_hold_r <= 1'b0;
    else if (!start_f_r) start_hold_r <= 1'b0;
    else if (wm_r[1] & edge_f[0]) start_hold_r <= 1'b1;
  end

  // open-drain drivers; stretching is slave-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      dout <= 1'b0;
    end else begin
      scl_oe_n_r <= ~(wm_r[1] & port_r[PT_SCLD] & (~port_r[PT_SCL] | start_hold_r
                      | ((wm_r == WM_TWO_HOLD) & wrap_f_r)));
      sda_oe_n_r <= ~(wm_r[1] & port_r[PT_SDAD] & (~latch_r | ~port_r[PT_SDA]));
      dout <= (wm_r == WM_THREE) & latch_r;
    end
  end

  // level request, flags are async-free so it works as a wake source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) event_req <= 1'b0;
    else event_req <= (start_f_r & sie_r) | (wrap_f_r & oie_r);
  end

  // apb slave, no wait state; answers come from flops loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      case (paddr)
        OFS_DATA: prdata <= {24'h0, data_r};
        OFS_BUF:  prdata <= {24'h0, buf_r};
        OFS_STAT: prdata <= {24'h0, start_f_r, wrap_f_r, stop_f_r, data_r[7] ^ filt_r[1], cnt_r};
        OFS_CTRL: prdata <= {24'h0, sie_r, oie_r, wm_r, cs_r, 2'h0};
        OFS_PORT: prdata <= {28'h0, port_r};
        default: begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign bus.dev_scl_o    = 1'b0;
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_scl_oe_n = scl_oe_n_r;
  assign bus.dev_sda_oe_n = sda_oe_n_r;
endmodule

// ==== usi_pkg.sv ====
package usi_pkg;
  // device register byte offsets
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_BUF    = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_PORT   = 8'h10;
  // host register byte offsets
  localparam logic [7:0] OFS_HCMD   = 8'h00;
  localparam logic [7:0] OFS_HSTAT  = 8'h04;
  // status register bit positions
  localparam int ST_START = 7;
  localparam int ST_WRAP  = 6;
  localparam int ST_STOP  = 5;
  localparam int ST_COLL  = 4;
  // control register bit positions
  localparam int CT_SIE   = 7;
  localparam int CT_OIE   = 6;
  localparam int CT_WM    = 4;
  localparam int CT_CS    = 2;
  localparam int CT_CLK   = 1;
  localparam int CT_TC    = 0;
  // port register bit positions
  localparam int PT_SCL   = 0;
  localparam int PT_SDA   = 1;
  localparam int PT_SCLD  = 2;
  localparam int PT_SDAD  = 3;
  // reset values and counter maximum
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] RST_PORT  = 4'h3;
  localparam logic [3:0] CNT_MAX   = 4'hF;
  // wire modes and clock selects
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;
  localparam logic [1:0] WM_THREE    = 2'h1;
  localparam logic [1:0] CS_SOFT     = 2'h0;
  localparam logic [1:0] CS_TIMER    = 2'h1;
  localparam logic [1:0] CS_EXT_POS  = 2'h2;
  localparam logic [1:0] CS_EXT_NEG  = 2'h3;
  // host commands
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_STOP  = 2'h3;
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  // host serial clock half period
  localparam int CLK_NS      = 100;
  localparam int SCL_HALF_NS = 2000;
  localparam logic [7:0] SCL_HALF_CYC = 8'((SCL_HALF_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_STRT = 7'h02,
    H_LOW  = 7'h04,
    H_RISE = 7'h08,
    H_HIGH = 7'h10,
    H_STOP = 7'h20,
    H_SREL = 7'h40
  } usi_hstate_t;
endpackage

// ==== usi_if.sv ====
`timescale 1ns/1ps
interface usi_if;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic scl;
  logic sda;
  // open-drain wired-and, released lines pulled high
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);
  modport dev  (input scl, sda, output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface

// ==== usi_host.sv ====
`timescale 1ns/1ps
module usi_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  usi_if.host              bus
);
  import usi_pkg::*;

  logic [1:0]  s1_r, s2_r, s3_r, filt_r;
  usi_hstate_t state_r;
  logic [7:0]  tmr_r;
  logic [3:0]  bitn_r;
  logic [8:0]  sh_r;
  logic [7:0]  rx_r;
  logic        ack_in_r;
  logic        scl_oe_n_r, sda_oe_n_r;
  logic        cmd_go;
  logic        busy;

  assign busy   = (state_r != H_IDLE);
  assign cmd_go = psel & penable & pready & pwrite & (paddr == OFS_HCMD) & ~busy;

  // pins: three stages, a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
      filt_r <= 2'h3;
    end else begin
      s1_r <= {bus.sda, bus.scl};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 2; i++) begin
        if (s2_r[i] == s3_r[i]) filt_r[i] <= s3_r[i];
      end
    end
  end

  // apb slave, no wait state; answers come from flops loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= (paddr != OFS_HCMD) && (paddr != OFS_HSTAT);
      prdata <= (paddr == OFS_HSTAT) ? {16'h0, rx_r, 6'h0, ack_in_r, busy} : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // bit engine; only this end makes the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= H_IDLE;
      tmr_r <= 8'h0;
      bitn_r <= 4'h0;
      sh_r <= 9'h1FF;
      rx_r <= RST_BYTE;
      ack_in_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      case (state_r)
        H_IDLE: begin
          tmr_r <= SCL_HALF_CYC;
          bitn_r <= 4'h0;
          if (cmd_go) begin
            case (pwdata[1:0])
              CMD_START: begin
                scl_oe_n_r <= 1'b1;
                sda_oe_n_r <= 1'b1;
                state_r <= H_STRT;
              end
              CMD_WRITE: begin
                sh_r <= {pwdata[15:8], 1'b1};
                sda_oe_n_r <= pwdata[15];
                state_r <= H_LOW;
              end
              CMD_READ: begin
                // slave drives data, master only acks
                sh_r <= {8'hFF, pwdata[2]};
                sda_oe_n_r <= 1'b1;
                state_r <= H_LOW;
              end
              default: begin
                sda_oe_n_r <= 1'b0;
                state_r <= H_STOP;
              end
            endcase
          end
        end
        H_STRT: begin
          // sda falls while scl is seen high
          if (!filt_r[0]) tmr_r <= SCL_HALF_CYC;
          else if (tmr_r != 8'h0) tmr_r <= tmr_r - 8'h1;
          else if (sda_oe_n_r) begin
            sda_oe_n_r <= 1'b0;
            tmr_r <= SCL_HALF_CYC;
          end else begin
            scl_oe_n_r <= 1'b0;
            state_r <= H_IDLE;
          end
        end
        H_LOW: begin
          if (tmr_r != 8'h0) tmr_r <= tmr_r - 8'h1;
          else begin
            scl_oe_n_r <= 1'b1;
            state_r <= H_RISE;
          end
        end
        H_RISE: begin
          // a stretching slave keeps us here
          if (filt_r[0]) begin
            sh_r <= {sh_r[7:0], filt_r[1]};
            tmr_r <= SCL_HALF_CYC;
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_r != 8'h0) tmr_r <= tmr_r - 8'h1;
          else begin
            scl_oe_n_r <= 1'b0;
            tmr_r <= SCL_HALF_CYC;
            if (bitn_r == BITS_PER_XFER) begin
              rx_r <= sh_r[8:1];
              ack_in_r <= sh_r[0];
              sda_oe_n_r <= 1'b1;
              state_r <= H_IDLE;
            end else begin
              bitn_r <= bitn_r + 4'h1;
              sda_oe_n_r <= sh_r[8];
              state_r <= H_LOW;
            end
          end
        end
        H_STOP: begin
          if (tmr_r != 8'h0) tmr_r <= tmr_r - 8'h1;
          else begin
            scl_oe_n_r <= 1'b1;
            tmr_r <= SCL_HALF_CYC;
            state_r <= H_SREL;
          end
        end
        H_SREL: begin
          if (filt_r[0]) begin
            if (tmr_r != 8'h0) tmr_r <= tmr_r - 8'h1;
            else begin
              sda_oe_n_r <= 1'b1;
              state_r <= H_IDLE;
            end
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = scl_oe_n_r;
  assign bus.host_sda_oe_n = sda_oe_n_r;
endmodule

// ==== usi_asserts.sv ====
`timescale 1ns/1ps
module usi_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // both device drivers and the host clock driver start released so the bus idles high
  chk_idle_release: assert property ($rose(presetn) |-> dev_scl_oe_n && dev_sda_oe_n && host_scl_oe_n)
    else $error("line driven right after reset");
  // master waits while the slave holds the clock low
  chk_host_wait: assert property (host_scl_oe_n && !scl |=> host_scl_oe_n)
    else $error("host pulled clock during stretch");
  chk_host_high: assert property ($rose(host_scl_oe_n) |=> host_scl_oe_n [*8])
    else $error("host clock high phase too short");
  // start: data falls with clock high, clock stays high for the detector
  chk_start_form: assert property ($fell(host_sda_oe_n) && scl |=> scl [*3])
    else $error("clock fell too soon after start");
  chk_stop_form: assert property ($rose(host_sda_oe_n) && host_scl_oe_n |-> scl)
    else $error("host released data with clock low");
  // the slave never makes a falling clock edge itself
  chk_stretch_late: assert property ($fell(dev_scl_oe_n) |-> !$past(scl))
    else $error("device pulled clock while high");
  chk_stretch_hold: assert property ($fell(dev_scl_oe_n) |=> !dev_scl_oe_n [*3])
    else $error("stretch released without clear");
  chk_dev_no_toggle: assert property ($rose(dev_scl_oe_n) |=> dev_scl_oe_n [*8])
    else $error("device clocked the bus");

  cov_start: cover property ($fell(sda) && scl);
  cov_stretch: cover property ($fell(dev_scl_oe_n));
  cov_dev_data: cover property ($fell(dev_sda_oe_n));
endmodule

// ==== test_usi_two_wire_serial.sv ====
`timescale 1ns/1ps
module test_usi_two_wire_serial;
  import usi_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        tim_match;
  logic        event_req;
  logic        dout;
  logic        psel    [2];
  logic        penable [2];
  logic        pwrite  [2];
  logic [7:0]  paddr   [2];
  logic [31:0] pwdata  [2];
  logic [31:0] prdata  [2];
  logic        pready  [2];
  logic        pslverr [2];
  logic [31:0] seed;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  adr;
  logic [7:0]  dat;
  logic [31:0] rst_exp [5];
  int          errors;
  int          comparisons;

  usi_if link ();
  usi_dev usi_dev_i (.pclk(pclk), .presetn(presetn), .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]),
    .paddr(paddr[0]), .pwdata(pwdata[0]), .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]),
    .tim_match(tim_match), .event_req(event_req), .dout(dout), .bus(link.dev));
  usi_host usi_host_i (.pclk(pclk), .presetn(presetn), .psel(psel[1]), .penable(penable[1]), .pwrite(pwrite[1]),
    .paddr(paddr[1]), .pwdata(pwdata[1]), .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]),
    .bus(link.host));
  usi_asserts usi_asserts_i (.pclk(pclk), .presetn(presetn), .scl(link.scl), .sda(link.sda),
    .dev_scl_oe_n(link.dev_scl_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
    .host_scl_oe_n(link.host_scl_oe_n), .host_sda_oe_n(link.host_sda_oe_n));

  // 10 MHz bench clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    errors++;
    $display("Error %s wait ran out", name);
    results();
  endtask

  // one transfer on port s (0 device, 1 host); read data and error land in rd and err
  task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel[s] <= 1'b1;
    pwrite[s] <= w;
    paddr[s] <= a;
    pwdata[s] <= wd;
    @(posedge pclk);
    penable[s] <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready[s] !== 1'b1 && n < 20);
    if (n >= 20) timeout("pready");
    rd = prdata[s];
    err = pslverr[s];
    psel[s] <= 1'b0;
    penable[s] <= 1'b0;
  endtask

  // poll a status bit of either end until it reads v; a byte takes some 125 polls
  task automatic poll(input int s, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(s, 1'b0, (s == 1) ? OFS_HSTAT : OFS_STAT, 32'h0);
      n++;
    end while (rd[b] !== v && n < 400);
    if (n >= 400) timeout("status poll");
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    seed = 32'h1;
    presetn = 1'b0;
    tim_match = 1'b0;
    // collision reads one at reset: data bit 7 is zero while idle sda is high
    rst_exp = '{32'h0, 32'h0, 32'h1 << ST_COLL, 32'h0, {28'h0, RST_PORT}};
    for (int s = 0; s < 2; s++) begin
      psel[s] = 1'b0;
      penable[s] = 1'b0;
      pwrite[s] = 1'b0;
      paddr[s] = 8'h0;
      pwdata[s] = 32'h0;
    end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only buffer, unmapped places
    foreach (rst_exp[i]) begin
      apb(0, 1'b0, 8'(4 * i), 32'h0);
      check("reset value", rst_exp[i], rd);
    end
    apb(0, 1'b1, OFS_BUF, 32'hFF);
    apb(0, 1'b0, OFS_BUF, 32'h0);
    check("buffer write", 32'h0, rd);
    apb(0, 1'b0, 8'h14, 32'h0);
    check("device unmapped", 32'h1, 32'(err));
    apb(1, 1'b0, 8'h08, 32'h0);
    check("host unmapped", 32'h1, 32'(err));
    // slave: hold mode, shift on clock rise, clock drive on, data drive off while receiving
    apb(0, 1'b1, OFS_PORT, 32'h7);
    apb(0, 1'b1, OFS_CTRL, {24'h0, 2'h0, WM_TWO_HOLD, CS_EXT_POS, 2'h0});
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      adr = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
      dat = seed[15:8];
      apb(1, 1'b1, OFS_HCMD, {30'h0, CMD_START});
      poll(1, 0, 1'b0);
      poll(0, ST_START, 1'b1);
      // the hold follows the clock fall through the synchroniser, give it time to settle
      repeat (2) @(posedge pclk);
      check("start stretch", 32'h0, 32'(link.dev_scl_oe_n));
      apb(0, 1'b1, OFS_STAT, 32'h80);
      apb(1, 1'b1, OFS_HCMD, {16'h0, adr, 6'h0, CMD_WRITE});
      poll(0, ST_WRAP, 1'b1);
      apb(0, 1'b0, OFS_DATA, 32'h0);
      check("address byte", {24'h0, adr}, rd);
      apb(0, 1'b0, OFS_BUF, 32'h0);
      check("buffer copy", {24'h0, adr}, rd);
      apb(0, 1'b0, OFS_STAT, 32'h0);
      check("collision", {31'h0, ~adr[7]}, 32'(rd[ST_COLL]));
      check("counter wrap", 32'h0, 32'(rd[3:0]));
      // acknowledge: data bit 7 low, counter 14, then one more wrap
      apb(0, 1'b1, OFS_PORT, 32'hF);
      apb(0, 1'b1, OFS_DATA, 32'h0);
      apb(0, 1'b1, OFS_STAT, 32'h4E);
      poll(0, ST_WRAP, 1'b1);
      apb(0, 1'b1, OFS_PORT, 32'h7);
      if (adr[0]) begin
        apb(0, 1'b1, OFS_DATA, {24'h0, dat});
        apb(0, 1'b1, OFS_PORT, 32'hF);
      end
      apb(0, 1'b1, OFS_STAT, 32'h40);
      poll(1, 0, 1'b0);
      check("address ack", 32'h0, 32'(rd[1]));
      apb(1, 1'b1, OFS_HCMD, adr[0] ? {29'h0, 1'b1, CMD_READ} : {16'h0, dat, 6'h0, CMD_WRITE});
      poll(0, ST_WRAP, 1'b1);
      apb(0, 1'b0, OFS_DATA, 32'h0);
      if (!adr[0]) check("data byte", {24'h0, dat}, rd);
      // release data and leave the last byte unacknowledged
      apb(0, 1'b1, OFS_PORT, 32'h7);
      apb(0, 1'b1, OFS_STAT, 32'h4E);
      poll(0, ST_WRAP, 1'b1);
      apb(0, 1'b1, OFS_STAT, 32'h40);
      poll(1, 0, 1'b0);
      check("host status", adr[0] ? {16'h0, dat, 8'h0} : 32'h2, rd & (adr[0] ? 32'hFF00 : 32'h2));
      apb(1, 1'b1, OFS_HCMD, {30'h0, CMD_STOP});
      poll(1, 0, 1'b0);
      poll(0, ST_STOP, 1'b1);
      apb(0, 1'b1, OFS_STAT, 32'h20);
      apb(0, 1'b0, OFS_STAT, 32'h0);
      check("stop clear", 32'h0, 32'(rd[ST_STOP]));
    end
    // outputs off: no start detection, but external select flags clock edges
    apb(0, 1'b1, OFS_CTRL, 32'h0);
    apb(0, 1'b1, OFS_STAT, 32'hE0);
    apb(1, 1'b1, OFS_HCMD, {30'h0, CMD_START});
    poll(1, 0, 1'b0);
    apb(0, 1'b0, OFS_STAT, 32'h0);
    check("start off", 32'h0, 32'(rd[ST_START]));
    apb(0, 1'b1, OFS_CTRL, {24'h0, 4'h0, CS_EXT_NEG, 2'h0});
    apb(1, 1'b1, OFS_HCMD, {30'h0, CMD_STOP});
    poll(1, 0, 1'b0);
    apb(0, 1'b0, OFS_STAT, 32'h0);
    check("edge flag", 32'h1, 32'(rd[ST_START]));
    // software strobe from a preset maximum count
    apb(0, 1'b1, OFS_STAT, 32'hEF);
    apb(0, 1'b1, OFS_DATA, 32'h81);
    // the strobe acts on the clock select already stored, so select software first
    apb(0, 1'b1, OFS_CTRL, 32'h40);
    apb(0, 1'b1, OFS_CTRL, 32'h42);
    apb(0, 1'b0, OFS_DATA, 32'h0);
    check("soft shift", 32'h03, rd);
    apb(0, 1'b0, OFS_STAT, 32'h0);
    check("soft wrap", 32'h40, rd & 32'h4F);
    check("wrap event", 32'h1, 32'(event_req));
    // one timer match pulse counts once
    apb(0, 1'b1, OFS_CTRL, {24'h0, 4'h0, CS_TIMER, 2'h0});
    apb(0, 1'b1, OFS_STAT, 32'h45);
    tim_match <= 1'b1;
    @(posedge pclk);
    tim_match <= 1'b0;
    apb(0, 1'b0, OFS_STAT, 32'h0);
    check("timer count", 32'h6, rd & 32'h4F);
    // three-wire mode, internal clock: latch open, data bit 7 reaches the output pin
    apb(0, 1'b1, OFS_CTRL, {24'h0, 2'h0, WM_THREE, CS_SOFT, 2'h0});
    apb(0, 1'b1, OFS_DATA, 32'h80);
    repeat (3) @(posedge pclk);
    check("data out high", 32'h1, 32'(dout));
    apb(0, 1'b1, OFS_DATA, 32'h7F);
    repeat (3) @(posedge pclk);
    check("data out low", 32'h0, 32'(dout));
    results();
  end
endmodule
